/* verilog/clk_sel_defs.svh */
`ifndef CLK_SEL_DEFS_SVH
`define CLK_SEL_DEFS_SVH

// =====================================================
// Register offsets
`define CS_SYSCFG_OFS 4'h0
`define CS_STATUS_OFS 4'h4
`define CS_MASK_OFS 4'h8
`define CS_STATE_OFS 4'hC

// =====================================================
// Field positions
`define CS_MONDIS_BIT 4
`define CS_FAIL_BIT 0

// =====================================================
// Reset values
`define CS_SYSCFG_RST 16'h0000
`define CS_STATUS_RST 16'h0000
`define CS_MASK_RST 16'h0000
`define CS_CNT_RST 5'h00

// =====================================================
// Monitor overflow count, in free-running PLL cycles
`define CS_MON_OVF 5'h10

// =====================================================
// Strap codes
`define CS_STRAP_X4 3'h7
`define CS_STRAP_X3 3'h6
`define CS_STRAP_X8 3'h5
`define CS_STRAP_X5 3'h4
`define CS_STRAP_DIRECT 3'h3
`define CS_STRAP_X10 3'h2
`define CS_STRAP_PRESC 3'h1
`define CS_STRAP_X16 3'h0

`endif

/* verilog/clk_sel_pkg.sv */
package clk_sel_pkg;

  // Where the core clock comes from
  typedef enum logic [1:0] {
    SRC_DIRECT,
    SRC_PRESCALE,
    SRC_PLL_MULT,
    SRC_BACKUP
  } core_src_t;

  // PLL divider chain setting
  typedef struct packed {
    logic [2:0] in_div;
    logic [6:0] vco_mul;
    logic [2:0] out_div;
    logic [4:0] factor;
  } pll_cfg_t;

  // Whole state of the selector
  typedef struct packed {
    logic capture;
    logic [2:0] strap;
    logic mon_dis;
    logic failed;
    logic [4:0] mon_cnt;
    logic xtal_prev;
    logic [4:0] sync_cnt;
    logic resync;
    logic [15:0] stat;
    logic [15:0] mask;
    logic [15:0] rdata;
  } state_t;

endpackage

/* verilog/clock_source_select.sv */
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "clk_sel_defs.svh"

module clock_source_select #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic bidir_reset_i,
  // Strap pins and clock sources
  input wire logic [2:0] clock_mode_straps_i,
  input wire logic crystal_input_pin_i,
  input wire logic pll_tick_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  // Clock control
  output clk_sel_pkg::core_src_t core_src_o,
  output clk_sel_pkg::pll_cfg_t pll_cfg_o,
  output logic pll_power_o,
  output logic pll_ref_connect_o,
  output logic osc_amp_bypass_o,
  output logic pll_resync_o,
  output logic clock_fail_o,
  // Interrupt
  output logic irq_o
);

  // ===================================================
  // State registers
  clk_sel_pkg::state_t st_ff;
  clk_sel_pkg::state_t nxt_st;
  clk_sel_pkg::state_t rst_st;

  // ===================================================
  // Decoded mode
  logic mode_direct;
  logic mode_presc;
  logic mode_pll;
  logic mon_active;
  logic xtal_edge;
  logic [4:0] cnt_inc;
  logic overflow;
  logic wr_syscfg;
  logic wr_status;
  logic wr_mask;
  logic [15:0] set_bits;
  logic [15:0] clr_bits;
  clk_sel_pkg::pll_cfg_t cfg;

  assign mode_direct = (st_ff.strap == `CS_STRAP_DIRECT);
  assign mode_presc = (st_ff.strap == `CS_STRAP_PRESC);
  assign mode_pll = !mode_direct && !mode_presc;
  assign mon_active = !mode_pll && !st_ff.mon_dis && !st_ff.failed && !st_ff.capture;
  assign xtal_edge = crystal_input_pin_i ^ st_ff.xtal_prev;
  assign cnt_inc = 5'(st_ff.mon_cnt + 5'h01);
  assign overflow = mon_active && pll_tick_i && !xtal_edge && (cnt_inc == `CS_MON_OVF);

  assign wr_syscfg = wr_i && (addr_i == `CS_SYSCFG_OFS);
  assign wr_status = wr_i && (addr_i == `CS_STATUS_OFS);
  assign wr_mask = wr_i && (addr_i == `CS_MASK_OFS);

  // ===================================================
  // PLL divider table
  // Divider chain per strap code
  always_comb
  begin
    cfg = '0;
    case (st_ff.strap)
      `CS_STRAP_X4:
      begin
        cfg.in_div = 3'h4;
        cfg.vco_mul = 7'h40;
        cfg.out_div = 3'h4;
        cfg.factor = 5'h04;
      end
      `CS_STRAP_X3:
      begin
        cfg.in_div = 3'h4;
        cfg.vco_mul = 7'h30;
        cfg.out_div = 3'h4;
        cfg.factor = 5'h03;
      end
      `CS_STRAP_X8:
      begin
        cfg.in_div = 3'h4;
        cfg.vco_mul = 7'h40;
        cfg.out_div = 3'h2;
        cfg.factor = 5'h08;
      end
      `CS_STRAP_X5:
      begin
        cfg.in_div = 3'h4;
        cfg.vco_mul = 7'h28;
        cfg.out_div = 3'h2;
        cfg.factor = 5'h05;
      end
      `CS_STRAP_X10:
      begin
        cfg.in_div = 3'h2;
        cfg.vco_mul = 7'h28;
        cfg.out_div = 3'h2;
        cfg.factor = 5'h0A;
      end
      `CS_STRAP_X16:
      begin
        cfg.in_div = 3'h2;
        cfg.vco_mul = 7'h40;
        cfg.out_div = 3'h2;
        cfg.factor = 5'h10;
      end
      default:
      begin
        cfg = '0;
      end
    endcase
  end

  // ===================================================
  // Reset image
  always_comb
  begin
    rst_st = '0;
    rst_st.mon_dis = 1'(`CS_SYSCFG_RST >> `CS_MONDIS_BIT);
    rst_st.capture = 1'b1;
    rst_st.mon_cnt = `CS_CNT_RST;
    rst_st.stat = `CS_STATUS_RST;
    rst_st.mask = `CS_MASK_RST;
  end

  // ===================================================
  // Next state
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.resync = 1'b0;
    nxt_st.xtal_prev = crystal_input_pin_i;
    set_bits = '0;
    clr_bits = '0;
    if (st_ff.capture)
    begin
      nxt_st.strap = clock_mode_straps_i;
      nxt_st.capture = 1'b0;
    end
    if (wr_syscfg)
    begin
      nxt_st.mon_dis = wdata_i[`CS_MONDIS_BIT];
    end
    if (wr_mask)
    begin
      nxt_st.mask = wdata_i;
    end
    if (!mon_active || xtal_edge)
    begin
      nxt_st.mon_cnt = `CS_CNT_RST;
    end
    else if (pll_tick_i)
    begin
      nxt_st.mon_cnt = overflow ? `CS_CNT_RST : cnt_inc;
    end
    if (overflow)
    begin
      nxt_st.failed = 1'b1;
      set_bits[`CS_FAIL_BIT] = 1'b1;
    end
    // Write one to clear, set wins
    if (wr_status)
    begin
      clr_bits = wdata_i;
    end
    nxt_st.stat = (st_ff.stat & ~clr_bits) | set_bits;
    if (mode_pll && xtal_edge && !st_ff.capture)
    begin
      if (st_ff.sync_cnt >= 5'(cfg.factor - 5'h01))
      begin
        nxt_st.sync_cnt = '0;
        nxt_st.resync = 1'b1;
      end
      else
      begin
        nxt_st.sync_cnt = 5'(st_ff.sync_cnt + 5'h01);
      end
    end
    // Register read data, zero for unmapped
    if (rd_i)
    begin
      case (addr_i)
        `CS_SYSCFG_OFS: nxt_st.rdata = 16'(nxt_mon_word(st_ff.mon_dis));
        `CS_STATUS_OFS: nxt_st.rdata = st_ff.stat;
        `CS_MASK_OFS: nxt_st.rdata = st_ff.mask;
        `CS_STATE_OFS: nxt_st.rdata = {5'h00, st_ff.mon_cnt, 2'(core_src_o),
          st_ff.failed, st_ff.strap};
        default: nxt_st.rdata = 16'h0000;
      endcase
    end
    if (bidir_reset_i)
    begin
      nxt_st = rst_st;
      nxt_st.xtal_prev = crystal_input_pin_i;
    end
  end

  function automatic logic [15:0] nxt_mon_word(input logic dis);
    logic [15:0] w;
    w = 16'h0000;
    w[`CS_MONDIS_BIT] = dis;
    return w;
  endfunction

  // ===================================================
  // State register
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_ff <= '{capture: 1'b1, mon_cnt: `CS_CNT_RST, stat: `CS_STATUS_RST,
        mask: `CS_MASK_RST, default: '0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ===================================================
  // Outputs
  always_comb
  begin
    if (st_ff.failed)
    begin
      core_src_o = clk_sel_pkg::SRC_BACKUP;
    end
    else if (mode_pll)
    begin
      core_src_o = clk_sel_pkg::SRC_PLL_MULT;
    end
    else if (mode_presc)
    begin
      core_src_o = clk_sel_pkg::SRC_PRESCALE;
    end
    else
    begin
      core_src_o = clk_sel_pkg::SRC_DIRECT;
    end
  end

  assign pll_cfg_o = mode_pll ? cfg : '0;
  assign pll_power_o = mode_pll || !st_ff.mon_dis || st_ff.failed;
  // Reference feeds PLL only in multiply mode
  assign pll_ref_connect_o = mode_pll && !st_ff.failed;
  assign osc_amp_bypass_o = mode_direct;
  assign pll_resync_o = st_ff.resync;
  assign clock_fail_o = st_ff.failed;
  assign rdata_o = st_ff.rdata;
  assign irq_o = |(st_ff.stat & st_ff.mask);

  // ===================================================
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_quiet_tick;
    mon_active && pll_tick_i && !xtal_edge && !bidir_reset_i;
  endsequence

  sequence s_fail_seen;
    st_ff.failed && st_ff.stat[`CS_FAIL_BIT];
  endsequence

  a_mon_default: assert property (st_ff.capture |-> !st_ff.mon_dis)
    else $error("monitor not enabled after reset");

  a_disable_write: assert property (
    wr_syscfg && wdata_i[`CS_MONDIS_BIT] && !bidir_reset_i |=> st_ff.mon_dis)
    else $error("disable bit write ignored");

  a_pll_no_count: assert property (mode_pll |-> st_ff.mon_cnt == 5'h00)
    else $error("monitor counting in multiply mode");

  a_tick_count: assert property (
    s_quiet_tick and (cnt_inc != `CS_MON_OVF) |=> st_ff.mon_cnt == $past(cnt_inc))
    else $error("counter missed a PLL cycle");

  a_edge_clear: assert property (xtal_edge && !st_ff.capture |=> st_ff.mon_cnt == 5'h00)
    else $error("crystal edge did not clear counter");

  a_overflow_fail: assert property (
    s_quiet_tick and (st_ff.mon_cnt == 5'h0F) |=> st_ff.failed)
    else $error("no failure after sixteen PLL cycles");

  a_fail_cause: assert property ($rose(st_ff.failed) |-> $past(st_ff.mon_cnt) == 5'h0F)
    else $error("failure without overflow");

  a_backup_src: assert property (
    st_ff.failed |-> core_src_o == clk_sel_pkg::SRC_BACKUP && pll_power_o)
    else $error("failed but not on backup clock");

  a_irq_flag: assert property ($rose(st_ff.failed) |-> s_fail_seen)
    else $error("failure did not raise flag");

  a_fail_sticky: assert property (st_ff.failed && !bidir_reset_i |=> st_ff.failed)
    else $error("backup clock released without reset");

  a_bidir_restore: assert property (bidir_reset_i |=> !st_ff.failed ##1
    core_src_o != clk_sel_pkg::SRC_BACKUP)
    else $error("bidirectional reset did not restore source");

  a_dis_source: assert property (
    st_ff.mon_dis && !mode_pll && !st_ff.failed |->
    core_src_o inside {clk_sel_pkg::SRC_DIRECT, clk_sel_pkg::SRC_PRESCALE})
    else $error("monitor off but not on crystal clock");

  a_pll_off: assert property (
    st_ff.mon_dis && !mode_pll && !st_ff.failed |-> !pll_power_o)
    else $error("PLL powered with monitor off");

  a_pll_mult: assert property (
    mode_pll && !st_ff.failed |-> pll_power_o && pll_cfg_o.factor != 5'h00)
    else $error("multiply mode without PLL");

  a_resync_period: assert property (
    pll_resync_o |-> $past(xtal_edge) && $past(mode_pll))
    else $error("resync without input transition");

  a_direct_bypass: assert property (mode_direct |-> osc_amp_bypass_o && !pll_ref_connect_o)
    else $error("direct drive not bypassed");

  a_flag_hold: assert property (
    st_ff.stat[`CS_FAIL_BIT] && !wr_status && !bidir_reset_i |=> st_ff.stat[`CS_FAIL_BIT])
    else $error("flag dropped without software clear");

endmodule

`default_nettype wire

/* testbench/crystal_source_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// External crystal or clock source
module crystal_source_model (
  // Clock
  input wire logic clk_i,
  // Control: run, half period in cycles, edge limit (0 = none)
  input wire logic run_i,
  input wire logic [3:0] half_i,
  input wire logic [7:0] limit_i,
  // Crystal pin
  output logic level_o
);
  logic [3:0] phase_ff;
  logic [7:0] edges_ff;
  logic level_ff;

  initial
  begin
    phase_ff = 4'h0;
    edges_ff = 8'h00;
    level_ff = 1'b0;
  end

  // Dead oscillator sticks at its last level
  always @(posedge clk_i)
  begin
    if (!run_i)
    begin
      phase_ff <= 4'h0;
      edges_ff <= 8'h00;
    end
    else if (limit_i == 8'h00 || edges_ff < limit_i)
    begin
      if (phase_ff >= half_i - 4'h1)
      begin
        phase_ff <= 4'h0;
        level_ff <= ~level_ff;
        edges_ff <= edges_ff + 8'h01;
      end
      else
        phase_ff <= phase_ff + 4'h1;
    end
  end

  assign level_o = level_ff;
endmodule
`default_nettype wire

/* testbench/clock_source_select_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "clk_sel_defs.svh"
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module clock_source_select_tb;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic bidir_reset_i = 1'b0;
  logic [2:0] clock_mode_straps_i = 3'h3;
  logic crystal_input_pin_i;
  logic pll_tick_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rdata_o;
  clk_sel_pkg::core_src_t core_src_o;
  clk_sel_pkg::core_src_t src_exp;
  clk_sel_pkg::pll_cfg_t pll_cfg_o;
  logic pll_power_o, pll_ref_connect_o, osc_amp_bypass_o, pll_resync_o, clock_fail_o, irq_o;
  logic run = 1'b0;
  logic [3:0] half = 4'h2;
  logic [7:0] limit = 8'h00;
  logic [15:0] rdv;
  logic mult;
  int num_errors = 0;
  int checked = 0;
  int resync_cnt = 0;

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (pll_resync_o === 1'b1) resync_cnt++;

  clock_source_select i_clock_source_select (.clk_i(clk_i), .reset_i(reset_i),
    .bidir_reset_i(bidir_reset_i), .clock_mode_straps_i(clock_mode_straps_i),
    .crystal_input_pin_i(crystal_input_pin_i), .pll_tick_i(pll_tick_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .core_src_o(core_src_o),
    .pll_cfg_o(pll_cfg_o), .pll_power_o(pll_power_o), .pll_ref_connect_o(pll_ref_connect_o),
    .osc_amp_bypass_o(osc_amp_bypass_o), .pll_resync_o(pll_resync_o),
    .clock_fail_o(clock_fail_o), .irq_o(irq_o));
  crystal_source_model i_crystal_source_model (.clk_i(clk_i), .run_i(run), .half_i(half),
    .limit_i(limit), .level_o(crystal_input_pin_i));

  function automatic clk_sel_pkg::pll_cfg_t exp_cfg(input logic [2:0] s);
    case (s)
      3'h7: return {3'h4, 7'h40, 3'h4, 5'h04};
      3'h6: return {3'h4, 7'h30, 3'h4, 5'h03};
      3'h5: return {3'h4, 7'h40, 3'h2, 5'h08};
      3'h4: return {3'h4, 7'h28, 3'h2, 5'h05};
      3'h2: return {3'h2, 7'h28, 3'h2, 5'h0A};
      3'h0: return {3'h2, 7'h40, 3'h2, 5'h10};
      default: return 18'h00000;
    endcase
  endfunction

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    rdv = rdata_o;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    rd_reg(a);
    `CHK(rdv, e)
  endtask

  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      pll_tick_i <= 1'b1;
    end
    @(posedge clk_i);
    pll_tick_i <= 1'b0;
  endtask

  task automatic hw_reset(input logic [2:0] s);
    @(posedge clk_i);
    clock_mode_straps_i <= s;
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic wait_fail();
    bit seen;
    seen = 1'b0;
    for (int i = 0; i < 4 && !seen; i++)
    begin
      @(posedge clk_i);
      #1;
      seen = (clock_fail_o === 1'b1);
    end
    if (!seen)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, clock_fail_o, 1'b1);
      report_and_stop();
    end
  endtask

  initial
  begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd_chk(`CS_SYSCFG_OFS, `CS_SYSCFG_RST);
    rd_chk(`CS_STATUS_OFS, `CS_STATUS_RST);
    rd_chk(`CS_MASK_OFS, `CS_MASK_RST);
    rd_chk(`CS_STATE_OFS, 16'h0003);
    wr_reg(4'h2, 16'hFFFF);
    rd_chk(4'h2, 16'h0000);
    $display("test defaults done");

    for (int s = 0; s < 8; s++)
    begin
      hw_reset(s[2:0]);
      mult = (s != 3 && s != 1);
      src_exp = (s == 3) ? clk_sel_pkg::SRC_DIRECT :
        (s == 1) ? clk_sel_pkg::SRC_PRESCALE : clk_sel_pkg::SRC_PLL_MULT;
      `CHK(core_src_o, src_exp)
      `CHK(pll_cfg_o, exp_cfg(s[2:0]))
      `CHK(osc_amp_bypass_o, (s == 3))
      `CHK(pll_power_o, 1'b1)
      `CHK(pll_ref_connect_o, mult)
    end
    $display("test straps done");

    hw_reset(3'h6);
    resync_cnt = 0;
    limit <= 8'h18;
    run <= 1'b1;
    ticks(80);
    `CHK(resync_cnt, 8)
    `CHK(clock_fail_o, 1'b0)
    `CHK(core_src_o, clk_sel_pkg::SRC_PLL_MULT)
    run <= 1'b0;
    limit <= 8'h00;
    $display("test multiply done");

    hw_reset(3'h3);
    half <= 4'hC;
    run <= 1'b1;
    ticks(60);
    `CHK(clock_fail_o, 1'b0)
    run <= 1'b0;
    repeat (2) @(posedge clk_i);
    ticks(15);
    repeat (3) @(posedge clk_i);
    `CHK(clock_fail_o, 1'b0)
    rd_chk(`CS_STATE_OFS, 16'h03C3);
    ticks(1);
    wait_fail();
    `CHK(core_src_o, clk_sel_pkg::SRC_BACKUP)
    `CHK(irq_o, 1'b0)
    rd_chk(`CS_STATUS_OFS, 16'h0001);
    wr_reg(`CS_MASK_OFS, 16'h0001);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    run <= 1'b1;
    ticks(40);
    `CHK(core_src_o, clk_sel_pkg::SRC_BACKUP)
    rd_chk(`CS_STATUS_OFS, 16'h0001);
    wr_reg(`CS_STATUS_OFS, 16'h0001);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    `CHK(clock_fail_o, 1'b1)
    rd_reg(`CS_STATE_OFS);
    `CHK(rdv[3], 1'b1)
    $display("test failure done");

    @(posedge clk_i);
    bidir_reset_i <= 1'b1;
    @(posedge clk_i);
    bidir_reset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    `CHK(core_src_o, clk_sel_pkg::SRC_DIRECT)
    `CHK(clock_fail_o, 1'b0)
    $display("test bidir reset done");

    wr_reg(`CS_SYSCFG_OFS, 16'h0010);
    rd_chk(`CS_SYSCFG_OFS, 16'h0010);
    `CHK(pll_power_o, 1'b0)
    run <= 1'b0;
    repeat (2) @(posedge clk_i);
    ticks(40);
    repeat (3) @(posedge clk_i);
    `CHK(clock_fail_o, 1'b0)
    `CHK(core_src_o, clk_sel_pkg::SRC_DIRECT)
    hw_reset(3'h1);
    ticks(16);
    wait_fail();
    `CHK(core_src_o, clk_sel_pkg::SRC_BACKUP)
    wr_reg(`CS_SYSCFG_OFS, 16'h0010);
    repeat (2) @(posedge clk_i);
    `CHK(clock_fail_o, 1'b1)
    `CHK(pll_power_o, 1'b1)
    hw_reset(3'h1);
    wr_reg(`CS_SYSCFG_OFS, 16'h0010);
    ticks(40);
    repeat (3) @(posedge clk_i);
    `CHK(core_src_o, clk_sel_pkg::SRC_PRESCALE)
    $display("test disable done");
    report_and_stop();
  end
endmodule
`default_nettype wire
